/* File: hw/i2sb_pkg.sv */
// Register map, field layout, reset values and build constants of the audio block-port unit.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits and a four-channel serial link.
package i2sb_pkg;
	localparam int NUM_CH = 4;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// Register byte offsets.
	localparam logic [11:0] OFS_RX_PORT    = 12'h1c0;
	localparam logic [11:0] OFS_RX_PTR_RST = 12'h1c4;
	localparam logic [11:0] OFS_TX_PORT    = 12'h1c8;
	localparam logic [11:0] OFS_TX_PTR_RST = 12'h1cc;
	localparam logic [11:0] OFS_RX_CH_EN   = 12'h1e0;
	localparam logic [11:0] OFS_TX_CH_EN   = 12'h1e4;
	localparam logic [11:0] OFS_PTR_STAT   = 12'h1e8;
	localparam logic [11:0] OFS_PARAM_TWO  = 12'h1f0;
	localparam logic [11:0] OFS_PARAM_ONE  = 12'h1f4;
	localparam logic [11:0] OFS_VERSION    = 12'h1f8;

	// Field positions.
	localparam int POS_PTR_RST   = 0;
	localparam int POS_RXWS0     = 0;
	localparam int POS_RXWS1     = 3;
	localparam int POS_RXWS2     = 7;
	localparam int POS_RXWS3     = 10;
	localparam int POS_TXWS0     = 16;
	localparam int POS_TXWS1     = 19;
	localparam int POS_TXWS2     = 22;
	localparam int POS_TXWS3     = 25;
	localparam int POS_TX_CHANS  = 9;
	localparam int POS_RX_CHANS  = 7;
	localparam int POS_RX_BLOCK  = 6;
	localparam int POS_TX_BLOCK  = 5;
	localparam int POS_MODE_EN   = 4;
	localparam int POS_FIFO_DEP  = 2;
	localparam int POS_BUS_WIDTH = 0;
	localparam int POS_STAT_RXCH = 0;
	localparam int POS_STAT_RXHF = 2;
	localparam int POS_STAT_TXCH = 8;
	localparam int POS_STAT_TXHF = 10;

	// Word size encoding shared by every word size field.
	localparam logic [2:0] WS_12 = 3'h0;
	localparam logic [2:0] WS_16 = 3'h1;
	localparam logic [2:0] WS_20 = 3'h2;
	localparam logic [2:0] WS_24 = 3'h3;
	localparam logic [2:0] WS_32 = 3'h4;

	// Build options as reported to software.
	localparam logic [2:0] RX_WORD_SIZE = WS_32;
	localparam logic [2:0] TX_WORD_SIZE = WS_32;
	localparam logic [1:0] CHANS_CODE   = 2'h3;
	localparam logic       HAS_RX       = 1'b1;
	localparam logic       HAS_TX       = 1'b1;
	localparam logic       HAS_MODE_EN  = 1'b1;
	localparam logic [1:0] FIFO_DEPTH   = 2'h3;
	localparam logic [1:0] BUS_W32      = 2'h2;
	// Arbitrary release value.
	localparam logic [31:0] VERSION_VAL = 32'h0000_0001;

	localparam logic [31:0] PARAM_TWO_VAL = (32'(RX_WORD_SIZE) << POS_RXWS0) | (32'(RX_WORD_SIZE) << POS_RXWS1)
		| (32'(RX_WORD_SIZE) << POS_RXWS2) | (32'(RX_WORD_SIZE) << POS_RXWS3);
	localparam logic [31:0] PARAM_ONE_VAL = (32'(TX_WORD_SIZE) << POS_TXWS0) | (32'(TX_WORD_SIZE) << POS_TXWS1)
		| (32'(TX_WORD_SIZE) << POS_TXWS2) | (32'(TX_WORD_SIZE) << POS_TXWS3)
		| (32'(CHANS_CODE) << POS_TX_CHANS) | (32'(CHANS_CODE) << POS_RX_CHANS)
		| (32'(HAS_RX) << POS_RX_BLOCK) | (32'(HAS_TX) << POS_TX_BLOCK) | (32'(HAS_MODE_EN) << POS_MODE_EN)
		| (32'(FIFO_DEPTH) << POS_FIFO_DEP) | (32'(BUS_W32) << POS_BUS_WIDTH);

	localparam logic [3:0]  CH_EN_RST = 4'h0;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : i2sb_pkg

/* File: hw/i2sb_sync.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or clock far below the core clock rate.
`timescale 1ns/1ns
module i2sb_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : i2sb_sync

/* File: hw/i2sb_top.sv */
// Audio block-port unit: AXI4-Lite registers, receive and transmit block ports and build parameters.
// Assumes the codec drives bit clock and word select; all link inputs are sampled by the core clock.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
module i2sb_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        link_sclk,
	input  wire logic        link_ws,
	input  wire logic [3:0]  link_sdi,
	output logic [3:0]       link_sdo
);
	localparam int NCH = i2sb_pkg::NUM_CH;
	function automatic logic [1:0] first_ch(input logic [3:0] en);
		logic [1:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i]) r = 2'(i);
		end
		return r;
	endfunction : first_ch
	// Wraps to the lowest enabled channel after the highest one.
	function automatic logic [1:0] next_ch(input logic [1:0] cur, input logic [3:0] en);
		logic [1:0] r;
		r = first_ch(en);
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && i > int'(cur)) r = 2'(i);
		end
		return r;
	endfunction : next_ch
	function automatic logic mapped(input logic [11:0] a);
		return a == i2sb_pkg::OFS_RX_PORT || a == i2sb_pkg::OFS_RX_PTR_RST || a == i2sb_pkg::OFS_TX_PORT
			|| a == i2sb_pkg::OFS_TX_PTR_RST || a == i2sb_pkg::OFS_RX_CH_EN || a == i2sb_pkg::OFS_TX_CH_EN
			|| a == i2sb_pkg::OFS_PTR_STAT || a == i2sb_pkg::OFS_PARAM_TWO || a == i2sb_pkg::OFS_PARAM_ONE
			|| a == i2sb_pkg::OFS_VERSION;
	endfunction : mapped
	// Write channel state.
	logic [11:0] aw_addr_q, aw_addr_d;
	logic        aw_full_q, aw_full_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        w_full_q, w_full_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        wr_go, awready_q, wready_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	always_comb begin
		aw_addr_d = aw_addr_q;
		aw_full_d = aw_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		w_full_d  = w_full_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid && !aw_full_q) begin
			aw_addr_d = {s_axi_awaddr[11:2], 2'b00};
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && !w_full_q) begin
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
			w_full_d = 1'b1;
		end
		if (wr_go) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = mapped(aw_addr_q) ? i2sb_pkg::RESP_OKAY : i2sb_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_addr_q <= '0;
			aw_full_q <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= i2sb_pkg::RESP_OKAY;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end else begin
			aw_addr_q <= aw_addr_d;
			aw_full_q <= aw_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			awready_q <= !aw_full_d;
			wready_q  <= !w_full_d;
		end
	end
	// Ready flags are registered copies of the free state, so the bus sees flop outputs only.
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	// Write decode.
	logic        wr_rx_rst, wr_tx_rst, wr_tx_port, wr_rx_en, wr_tx_en;
	logic [31:0] w_masked;
	logic [3:0]  rx_en_q, rx_en_d, tx_en_q, tx_en_d;
	assign w_masked   = w_data_q & {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_rx_rst  = wr_go && aw_addr_q == i2sb_pkg::OFS_RX_PTR_RST && w_masked[i2sb_pkg::POS_PTR_RST];
	assign wr_tx_rst  = wr_go && aw_addr_q == i2sb_pkg::OFS_TX_PTR_RST && w_masked[i2sb_pkg::POS_PTR_RST];
	assign wr_tx_port = wr_go && aw_addr_q == i2sb_pkg::OFS_TX_PORT && (|w_strb_q);
	assign wr_rx_en   = wr_go && aw_addr_q == i2sb_pkg::OFS_RX_CH_EN && w_strb_q[0];
	assign wr_tx_en   = wr_go && aw_addr_q == i2sb_pkg::OFS_TX_CH_EN && w_strb_q[0];
	// Read channel state; only the enable registers, the transmit port and the pointer resets act on writes, so parameter writes change nothing.
	logic        rd_go, rd_rx_port;
	logic [11:0] rd_addr;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [1:0]  rx_ch_q, rx_ch_d, tx_ch_q, tx_ch_d;
	logic        rx_half_q, rx_half_d, tx_half_q, tx_half_d;
	logic [NCH-1:0][31:0] rx_l_w, rx_r_w;
	assign rd_addr    = {s_axi_araddr[11:2], 2'b00};
	assign rd_go      = s_axi_arvalid && arready_q;
	assign rd_rx_port = rd_go && rd_addr == i2sb_pkg::OFS_RX_PORT;
	always_comb begin
		rx_en_d   = wr_rx_en ? w_masked[NCH-1:0] : rx_en_q;
		tx_en_d   = wr_tx_en ? w_masked[NCH-1:0] : tx_en_q;
		rx_ch_d   = rx_ch_q;
		rx_half_d = rx_half_q;
		tx_ch_d   = tx_ch_q;
		tx_half_d = tx_half_q;
		// A pointer reset beats a port access in the same cycle.
		if (wr_rx_rst) begin
			rx_ch_d   = first_ch(rx_en_q);
			rx_half_d = 1'b0;
		end else if (rd_rx_port) begin
			rx_half_d = !rx_half_q;
			if (rx_half_q) rx_ch_d = next_ch(rx_ch_q, rx_en_q);
		end
		if (wr_tx_rst) begin
			tx_ch_d   = first_ch(tx_en_q);
			tx_half_d = 1'b0;
		end else if (wr_tx_port) begin
			tx_half_d = !tx_half_q;
			if (tx_half_q) tx_ch_d = next_ch(tx_ch_q, tx_en_q);
		end
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (rd_go) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = mapped(rd_addr) ? i2sb_pkg::RESP_OKAY : i2sb_pkg::RESP_SLVERR;
			case (rd_addr)
				i2sb_pkg::OFS_RX_PORT:   rdata_d = rx_half_q ? rx_r_w[rx_ch_q] : rx_l_w[rx_ch_q];
				i2sb_pkg::OFS_RX_CH_EN:  rdata_d = 32'(rx_en_q);
				i2sb_pkg::OFS_TX_CH_EN:  rdata_d = 32'(tx_en_q);
				i2sb_pkg::OFS_PTR_STAT:  rdata_d = (32'(rx_ch_q) << i2sb_pkg::POS_STAT_RXCH)
					| (32'(rx_half_q) << i2sb_pkg::POS_STAT_RXHF) | (32'(tx_ch_q) << i2sb_pkg::POS_STAT_TXCH)
					| (32'(tx_half_q) << i2sb_pkg::POS_STAT_TXHF);
				i2sb_pkg::OFS_PARAM_TWO: rdata_d = i2sb_pkg::PARAM_TWO_VAL;
				i2sb_pkg::OFS_PARAM_ONE: rdata_d = i2sb_pkg::PARAM_ONE_VAL;
				i2sb_pkg::OFS_VERSION:   rdata_d = i2sb_pkg::VERSION_VAL;
				default:                 rdata_d = '0;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_en_q   <= i2sb_pkg::CH_EN_RST;
			tx_en_q   <= i2sb_pkg::CH_EN_RST;
			rx_ch_q   <= '0;
			rx_half_q <= 1'b0;
			tx_ch_q   <= '0;
			tx_half_q <= 1'b0;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= i2sb_pkg::RESP_OKAY;
		end else begin
			rx_en_q   <= rx_en_d;
			tx_en_q   <= tx_en_d;
			rx_ch_q   <= rx_ch_d;
			rx_half_q <= rx_half_d;
			tx_ch_q   <= tx_ch_d;
			tx_half_q <= tx_half_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	// Serial link, sampled by the core clock; bit clock must stay below a quarter of it.
	logic [NCH-1:0] sdi_s;
	logic           sclk_s, ws_s;
	logic           sclk_prev_q, ws_rx_q, ws_tx_q;
	logic           rise, fall, ws_chg_rx, ws_chg_tx;
	i2sb_sync #(.W(NCH + 2)) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        ({link_sdi, link_ws, link_sclk}),
		.q        ({sdi_s, ws_s, sclk_s})
	);
	assign rise      = sclk_s && !sclk_prev_q;
	assign fall      = !sclk_s && sclk_prev_q;
	assign ws_chg_rx = rise && ws_s != ws_rx_q;
	assign ws_chg_tx = fall && ws_s != ws_tx_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_prev_q <= 1'b0;
			ws_rx_q     <= 1'b0;
			ws_tx_q     <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			ws_rx_q     <= rise ? ws_s : ws_rx_q;
			ws_tx_q     <= fall ? ws_s : ws_tx_q;
		end
	end
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [31:0] rsh_q, rsh_d, rl_q, rl_d, rr_q, rr_d;
		logic [31:0] tl_q, tl_d, tr_q, tr_d, tsh_q, tsh_d, word;
		logic        sdo_q, sdo_d;
		always_comb begin
			rsh_d = rsh_q;
			rl_d  = rl_q;
			rr_d  = rr_q;
			if (ws_chg_rx) begin
				// The word just finished belongs to the side that word select was on.
				if (ws_rx_q) rr_d = rsh_q;
				else rl_d = rsh_q;
				rsh_d = {31'h0, sdi_s[c]};
			end else if (rise) begin
				rsh_d = {rsh_q[30:0], sdi_s[c]};
			end
			tl_d = (wr_tx_port && tx_ch_q == 2'(c) && !tx_half_q) ? w_masked : tl_q;
			tr_d = (wr_tx_port && tx_ch_q == 2'(c) && tx_half_q) ? w_masked : tr_q;
			word  = ws_s ? tr_q : tl_q;
			tsh_d = tsh_q;
			sdo_d = sdo_q;
			if (ws_chg_tx) begin
				sdo_d = tx_en_q[c] && word[31];
				tsh_d = {word[30:0], 1'b0};
			end else if (fall) begin
				sdo_d = tx_en_q[c] && tsh_q[31];
				tsh_d = {tsh_q[30:0], 1'b0};
			end
		end
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				rsh_q <= '0;
				rl_q  <= '0;
				rr_q  <= '0;
				tl_q  <= '0;
				tr_q  <= '0;
				tsh_q <= '0;
				sdo_q <= 1'b0;
			end else begin
				rsh_q <= rsh_d;
				rl_q  <= rl_d;
				rr_q  <= rr_d;
				tl_q  <= tl_d;
				tr_q  <= tr_d;
				tsh_q <= tsh_d;
				sdo_q <= sdo_d;
			end
		end
		assign rx_l_w[c]   = rl_q;
		assign rx_r_w[c]   = rr_q;
		assign link_sdo[c] = sdo_q;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	rx_ptr_reset_a: assert property (wr_rx_rst |=> rx_ch_q == first_ch(rx_en_q) && !rx_half_q)
		else $error("receive pointer not at lowest enabled channel");
	tx_ptr_reset_a: assert property (wr_tx_rst |=> tx_ch_q == first_ch(tx_en_q) && !tx_half_q)
		else $error("transmit pointer not at lowest enabled channel");
	tx_port_step_a: assert property (wr_tx_port && !wr_tx_rst && tx_half_q && !wr_tx_en |=>
		!tx_half_q && tx_ch_q == next_ch($past(tx_ch_q), tx_en_q)) else $error("transmit port did not step");
	rx_port_half_a: assert property (rd_rx_port && !wr_rx_rst && !rx_half_q |=>
		rx_half_q && $stable(rx_ch_q)) else $error("receive port did not move to right half");
	param_two_a: assert property (rd_go && rd_addr == i2sb_pkg::OFS_PARAM_TWO |=>
		rvalid_q && rdata_q == i2sb_pkg::PARAM_TWO_VAL && rdata_q[31:13] == '0) else $error("parameter two wrong");
	chan_count_a: assert property (rd_go && rd_addr == i2sb_pkg::OFS_PARAM_ONE |=>
		rdata_q[10:9] == i2sb_pkg::CHANS_CODE && rdata_q[8:7] == i2sb_pkg::CHANS_CODE) else $error("channel codes wrong");
	param_one_a: assert property (rd_go && rd_addr == i2sb_pkg::OFS_PARAM_ONE |=>
		rdata_q[18:16] == i2sb_pkg::TX_WORD_SIZE && rdata_q[6:0] == {3'h7, i2sb_pkg::FIFO_DEPTH, i2sb_pkg::BUS_W32})
		else $error("parameter one fields wrong");
	version_a: assert property (rd_go && rd_addr == i2sb_pkg::OFS_VERSION |=>
		rvalid_q && rdata_q == i2sb_pkg::VERSION_VAL) else $error("version value wrong");
	ro_write_a: assert property (wr_go && aw_addr_q == i2sb_pkg::OFS_PARAM_ONE |=>
		bvalid_q && bresp_q == i2sb_pkg::RESP_OKAY && $stable(rx_en_q) && $stable(tx_en_q))
		else $error("read-only write had an effect");
	wo_read_zero_a: assert property (rd_go && rd_addr == i2sb_pkg::OFS_TX_PTR_RST |=> rdata_q == '0)
		else $error("pointer reset register did not read zero");
	cov_rx_wrap_c: cover property (rd_rx_port && rx_half_q && rx_ch_q != first_ch(rx_en_q) ##1 rx_ch_q == first_ch(rx_en_q));
	cov_tx_reset_mid_c: cover property (tx_half_q ##0 wr_tx_rst);
	cov_rx_capture_c: cover property (ws_chg_rx && ws_rx_q);
	cov_unmapped_c: cover property (bvalid_q && bresp_q == i2sb_pkg::RESP_SLVERR);
endmodule : i2sb_top

/* File: tb/i2sb_codec.sv */
// Behavioural audio codec on the far side of the serial link.
// Assumes a frame is started just after a core clock edge; the bit clock stands still between frames.
`timescale 1ns/1ns
module i2sb_codec (
	output logic            link_sclk,
	output logic            link_ws,
	output logic [3:0]      link_sdi,
	input  wire logic [3:0] link_sdo
);
	logic [31:0] send_l [4];
	logic [31:0] send_r [4];
	logic [31:0] got_l  [4];
	logic [31:0] got_r  [4];

	// The bit clock idles high so every frame opens with a real falling edge.
	initial begin
		link_sclk = 1'b1;
		link_ws   = 1'b0;
		link_sdi  = 4'h0;
	end

	// A lead bit with word select high forces a change at the first left bit, and the trailing
	// bit latches the right word; data lines outside the words toggle so stale bits never match.
	task automatic frame();
		#3;
		for (int i = -1; i < 65; i++) begin
			#80;
			link_sclk = 1'b0;
			link_ws   = (i < 0) || (i >= 32 && i < 64);
			for (int c = 0; c < 4; c++) begin
				if (i >= 0 && i < 64)
					link_sdi[c] = (i < 32) ? send_l[c][31-i] : send_r[c][63-i];
				else
					link_sdi[c] = ~link_sdi[c];
			end
			#80;
			link_sclk = 1'b1;
			for (int c = 0; c < 4; c++) begin
				if (i >= 0 && i < 32)
					got_l[c][31-i] = link_sdo[c];
				else if (i >= 32 && i < 64)
					got_r[c][63-i] = link_sdo[c];
			end
		end
	endtask : frame
endmodule : i2sb_codec

/* File: tb/i2s_block_dma_and_params_test.sv */
// Self-checking bench for the audio block-port unit: AXI4-Lite registers and the serial link.
// Assumes the codec model is the only driver of the link inputs.
`timescale 1ns/1ns
module i2s_block_dma_and_params_test;
	logic        core_clk;
	logic        rst_b         = 1'b0;
	logic [11:0] s_axi_awaddr  = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata   = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb   = 4'h0;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready  = 1'b0;
	logic [11:0] s_axi_araddr  = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready  = 1'b0;
	logic        link_sclk;
	logic        link_ws;
	logic [3:0]  link_sdi;
	logic [3:0]  link_sdo;
	logic [33:0] rq [$];
	logic [1:0]  bq [$];
	int          errors        = 0;
	int          checks        = 0;
	logic [31:0] seed          = 32'h0000_c356;
	logic [1:0]  rc;
	logic [1:0]  tc;
	logic        rh;
	logic        th;
	logic [31:0] tw [4];

	i2sb_top dut (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .link_sclk, .link_ws, .link_sdi, .link_sdo);
	i2sb_codec codec (.link_sclk, .link_ws, .link_sdi, .link_sdo);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic fail(input string m, input logic [33:0] g, input logic [33:0] e);
		errors++;
		$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
	endtask : fail

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
		input logic [1:0] e = i2sb_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge core_clk);
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		if (n >= 50) begin
			fail("write hang", 34'h0, 34'h0);
			end_of_test();
		end
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = i2sb_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge core_clk);
		rq.push_back({e, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		if (n >= 50) begin
			fail("read hang", 34'h0, 34'h0);
			end_of_test();
		end
	endtask : axr

	// Responses are matched in issue order against the notes left by the bus tasks.
	always @(posedge core_clk) begin : mon
		logic [33:0] e;
		if (rst_b && s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			checks++;
			if ({s_axi_rresp, s_axi_rdata} !== e)
				fail("read data", {s_axi_rresp, s_axi_rdata}, e);
		end
		if (rst_b && s_axi_bvalid && s_axi_bready) begin
			e = {32'h0000_0000, bq.pop_front()};
			checks++;
			if ({32'h0000_0000, s_axi_bresp} !== e)
				fail("write response", {32'h0000_0000, s_axi_bresp}, e);
		end
	end

	task automatic params();
		axr(i2sb_pkg::OFS_PARAM_TWO, 32'h0000_1224);
		axr(i2sb_pkg::OFS_PARAM_ONE, 32'h0924_07fe);
		axr(i2sb_pkg::OFS_VERSION, i2sb_pkg::VERSION_VAL);
	endtask : params

	// Pointer model: left then right, then on to the next enabled channel with wrap.
	task automatic step(inout logic [1:0] ch, inout logic h, input logic [3:0] en);
		h = ~h;
		if (!h) begin
			ch = ch + 2'h1;
			while (!en[ch])
				ch = ch + 2'h1;
		end
	endtask : step

	task automatic chk_stat();
		axr(i2sb_pkg::OFS_PTR_STAT, {21'h0, th, tc, 5'h0, rh, rc});
	endtask : chk_stat

	initial begin
		logic [31:0] el;
		logic [31:0] er;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		params();
		axw(i2sb_pkg::OFS_PARAM_TWO, rnd());
		axw(i2sb_pkg::OFS_PARAM_ONE, rnd());
		axw(i2sb_pkg::OFS_VERSION, rnd());
		params();
		axw(12'h0fc, rnd(), 4'hf, i2sb_pkg::RESP_SLVERR);
		axr(12'h0fc, 32'h0000_0000, i2sb_pkg::RESP_SLVERR);
		axr(i2sb_pkg::OFS_TX_PTR_RST, 32'h0000_0000);
		axr(i2sb_pkg::OFS_TX_PORT, 32'h0000_0000);
		axw(i2sb_pkg::OFS_RX_PORT, rnd());
		$display("test registers done");
		axw(i2sb_pkg::OFS_TX_CH_EN, 32'h0000_000a);
		axw(i2sb_pkg::OFS_TX_PTR_RST, 32'h0000_0001);
		{tc, th, rc, rh} = {2'h1, 1'b0, 2'h0, 1'b0};
		chk_stat();
		axw(i2sb_pkg::OFS_TX_PORT, rnd());
		step(tc, th, 4'ha);
		axw(i2sb_pkg::OFS_TX_PTR_RST, 32'hffff_fffe);
		chk_stat();
		axw(i2sb_pkg::OFS_TX_PTR_RST, 32'h0000_0001);
		th = 1'b0;
		chk_stat();
		for (int i = 0; i < 4; i++) begin
			tw[i] = rnd();
			axw(i2sb_pkg::OFS_TX_PORT, tw[i], (i == 0) ? 4'h3 : 4'hf);
			step(tc, th, 4'ha);
			chk_stat();
		end
		// Unstrobed bytes of the first word are stored as zero.
		tw[0][31:16] = 16'h0000;
		axw(i2sb_pkg::OFS_RX_CH_EN, 32'h0000_0006);
		axw(i2sb_pkg::OFS_RX_PTR_RST, 32'h0000_0001);
		{rc, rh} = {2'h1, 1'b0};
		for (int c = 0; c < 4; c++) begin
			codec.send_l[c] = rnd();
			codec.send_r[c] = rnd();
		end
		codec.frame();
		for (int c = 0; c < 4; c++) begin
			el = (c == 1) ? tw[0] : (c == 3) ? tw[2] : 32'h0000_0000;
			er = (c == 1) ? tw[1] : (c == 3) ? tw[3] : 32'h0000_0000;
			checks += 2;
			if (codec.got_l[c] !== el)
				fail("left serial word", {2'h0, codec.got_l[c]}, {2'h0, el});
			if (codec.got_r[c] !== er)
				fail("right serial word", {2'h0, codec.got_r[c]}, {2'h0, er});
		end
		$display("test transmit done");
		axr(i2sb_pkg::OFS_RX_PORT, codec.send_l[1]);
		step(rc, rh, 4'h6);
		chk_stat();
		axw(i2sb_pkg::OFS_RX_PTR_RST, 32'h0000_0001);
		rh = 1'b0;
		chk_stat();
		for (int i = 0; i < 5; i++) begin
			axr(i2sb_pkg::OFS_RX_PORT, rh ? codec.send_r[rc] : codec.send_l[rc]);
			step(rc, rh, 4'h6);
			chk_stat();
		end
		$display("test receive done");
		end_of_test();
	end
endmodule : i2s_block_dma_and_params_test
